// File: hw/lapg_consts.vh
`ifndef LAPG_CONSTS_VH
`define LAPG_CONSTS_VH

// Register byte offsets on the AXI4-Lite slave
`define LAPG_OFF_T3_0 8'h00
`define LAPG_OFF_T3_1 8'h04
`define LAPG_OFF_T3_2 8'h08
`define LAPG_OFF_T3_3 8'h0c
`define LAPG_OFF_T4D 8'h10
`define LAPG_OFF_T4M 8'h14
`define LAPG_OFF_CTRL 8'h18
`define LAPG_OFF_STAT 8'h1c

// Register indices returned by the address decoder
`define LAPG_IDX_T4D 4'h4
`define LAPG_IDX_T4M 4'h5
`define LAPG_IDX_CTRL 4'h6
`define LAPG_IDX_STAT 4'h7
`define LAPG_IDX_NONE 4'hf

// Configuration bit numbers carried by the registers
`define LAPG_T3_LOW_FIRST 592
`define LAPG_T3_LOW_LAST 655
`define LAPG_T4M_FIRST 656
`define LAPG_T4M_LAST 671
`define LAPG_T3_HIGH_FIRST 714
`define LAPG_T3_HIGH_LAST 777
`define LAPG_T4D_FIRST 778
`define LAPG_T4D_LAST 793

// Control fields and reset values
`define LAPG_CTRL_MODE 0
`define LAPG_CTRL_LEN_LSB 4
`define LAPG_CTRL_LEN_MSB 7
`define LAPG_LEN_RST 4'hf
`define LAPG_LEN_MIN 4'h1
`define LAPG_WORD_RST 32'h0000_0000
`define LAPG_HALF_RST 16'h0000

// AXI responses
`define LAPG_RESP_OKAY 2'h0
`define LAPG_RESP_SLVERR 2'h2

`endif

// File: hw/lapg_lut_cell.v
`timescale 1ns/100ps
// Combinational lookup cell: output is the table bit indexed by the inputs
module lapg_lut_cell #(
  parameter WIDTH = 3
) (
  input wire [(1 << WIDTH) - 1:0] table_bits,
  input wire [WIDTH - 1:0] sel_in,
  output wire sel_out
);

  // Input zero picks bit 0, all ones picks the top bit; no storage
  assign sel_out = table_bits[sel_in]; // [RULE1] [RULE5] [RULE11]

endmodule // lapg_lut_cell

// File: hw/lapg_top.v
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/100ps
// Function
// [RULE1] Three-input table outputs its config bit indexed by inputs, 000 picks lowest.
// [RULE2] Sixteen three-input tables use bits 592-655 and 714-777, ascending, eight each.
// [RULE3] Standard three-input patterns, MSB first, give AND, NAND, OR, NOR, XOR, XNOR.
// [RULE4] Dedicated four-input table takes inputs from and returns output to matrix 1.
// [RULE5] Dedicated four-input table outputs bit 778 plus input value, up to 793.
// [RULE6] Standard sixteen-bit patterns, MSB first, give the four-input gates.
// [RULE7] Macrocell works as four-input table or pattern generator, one at a time.
// [RULE8] Lookup mode: macrocell inputs and output use matrix 0, any truth table.
// [RULE9] Generator mode: repeating user sequence of two to sixteen bits.
// [RULE10] Lookup mode truth table is bits 656-671, input 0000 picks 656.
// [RULE11] All table outputs are purely combinational with no storage.
// [RULE12] Generator advances each rising matrix clock edge, restarts at first bit on reset; here clock pulses that rise and fall while ce is low are lost.
`include "lapg_consts.vh"

module lapg_top (
  input wire aclk,
  input wire aresetn,
  input wire ce,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [47:0] m_lut3_in,
  output wire [15:0] m_lut3_out,
  input wire [3:0] m1_table_in,
  output wire m1_table_out,
  input wire [3:0] m0_cell_in,
  input wire m0_pattern_generator_clk,
  output wire m0_cell_out
);

  // Configuration words; tables 0-7 in words 0-1, tables 8-15 in words 2-3
  reg [31:0] t3_reg [0:3];
  reg [15:0] t4d_reg;
  reg [15:0] t4m_reg;
  reg mode_reg;
  reg [3:0] len_reg;
  reg [3:0] pos_reg;
  reg [3:0] pos_next;
  reg clk_s1_reg;
  reg clk_s2_reg;
  reg clk_s3_reg;
  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire [127:0] t3_flat;
  wire [3:0] m0_lut_sel;
  wire m0_lut_out;
  wire pattern_generator_edge;
  wire [3:0] len_eff;
  wire [3:0] wr_idx;
  wire [3:0] rd_idx;
  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire [31:0] t4d_wr_word;
  wire [31:0] t4m_wr_word;
  genvar gi;

  // Address decode shared by the write and read paths
  function [3:0] lapg_dec;
    input [7:0] addr;
    begin
      if (addr == `LAPG_OFF_T3_0) begin
        lapg_dec = 4'h0;
      end else if (addr == `LAPG_OFF_T3_1) begin
        lapg_dec = 4'h1;
      end else if (addr == `LAPG_OFF_T3_2) begin
        lapg_dec = 4'h2;
      end else if (addr == `LAPG_OFF_T3_3) begin
        lapg_dec = 4'h3;
      end else if (addr == `LAPG_OFF_T4D) begin
        lapg_dec = `LAPG_IDX_T4D;
      end else if (addr == `LAPG_OFF_T4M) begin
        lapg_dec = `LAPG_IDX_T4M;
      end else if (addr == `LAPG_OFF_CTRL) begin
        lapg_dec = `LAPG_IDX_CTRL;
      end else if (addr == `LAPG_OFF_STAT) begin
        lapg_dec = `LAPG_IDX_STAT;
      end else begin
        lapg_dec = `LAPG_IDX_NONE;
      end
    end
  endfunction

  // Byte-lane merge of a write into an existing word
  function [31:0] lapg_merge;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0] strb;
    integer b;
    begin
      lapg_merge = old_word;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          lapg_merge[b * 8 +: 8] = new_word[b * 8 +: 8];
        end
      end
    end
  endfunction

  // Ascending eight-bit slices, table n at bits 8n+7:8n of the flat vector
  assign t3_flat = {t3_reg[3], t3_reg[2], t3_reg[1], t3_reg[0]}; // [RULE2]

  // Sixteen three-input tables; gate patterns need no special casing
  generate
    for (gi = 0; gi < 16; gi = gi + 1) begin : g_lut3
      lapg_lut_cell #(.WIDTH(3)) u_lut3 (
        .table_bits(t3_flat[gi * 8 +: 8]), // [RULE1] [RULE2] [RULE3]
        .sel_in(m_lut3_in[gi * 3 +: 3]),
        .sel_out(m_lut3_out[gi])
      );
    end
  endgenerate

  // Dedicated table sits wholly on matrix 1
  lapg_lut_cell #(.WIDTH(4)) u_t4d (
    .table_bits(t4d_reg), // [RULE4] [RULE5] [RULE6]
    .sel_in(m1_table_in),
    .sel_out(m1_table_out)
  );

  // Macrocell table, matrix 0; in generator mode it indexes the pattern
  assign m0_lut_sel = mode_reg ? pos_reg : m0_cell_in; // [RULE7]
  lapg_lut_cell #(.WIDTH(4)) u_t4m (
    .table_bits(t4m_reg), // [RULE8] [RULE10] [RULE6]
    .sel_in(m0_lut_sel),
    .sel_out(m0_lut_out)
  );
  assign m0_cell_out = m0_lut_out; // [RULE11]

  // Matrix clock is foreign to aclk; s1 only feeds s2
  always @(posedge aclk) begin
    if (!aresetn) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
    end else if (ce) begin
      clk_s1_reg <= m0_pattern_generator_clk;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
    end
  end
  assign pattern_generator_edge = clk_s2_reg & ~clk_s3_reg;

  // A length field of zero would give a one-bit loop, so floor it at one, giving a two-bit loop
  assign len_eff = (len_reg < `LAPG_LEN_MIN) ? `LAPG_LEN_MIN : len_reg;

  // Wrap after the last selected bit; hold at first bit in lookup mode
  always @* begin
    pos_next = pos_reg;
    if (!mode_reg) begin
      pos_next = 4'h0;
    end else if (pattern_generator_edge) begin
      if (pos_reg >= len_eff) begin
        pos_next = 4'h0; // [RULE9]
      end else begin
        pos_next = pos_reg + 4'h1; // [RULE12]
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_reg <= 4'h0; // [RULE12]
    end else if (ce) begin
      pos_reg <= pos_next;
    end
  end

  // Write channel: address and data taken independently, in either order
  assign aw_take = s_axi_awvalid & s_axi_awready;
  assign w_take = s_axi_wvalid & s_axi_wready;
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;
  assign wr_idx = lapg_dec(awaddr_reg);
  assign rd_idx = lapg_dec(s_axi_araddr);
  assign t4d_wr_word = lapg_merge({16'h0000, t4d_reg}, wdata_reg, wstrb_reg);
  assign t4m_wr_word = lapg_merge({16'h0000, t4m_reg}, wdata_reg, wstrb_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LAPG_RESP_OKAY;
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= `LAPG_WORD_RST;
      wstrb_reg <= 4'h0;
      t3_reg[0] <= `LAPG_WORD_RST;
      t3_reg[1] <= `LAPG_WORD_RST;
      t3_reg[2] <= `LAPG_WORD_RST;
      t3_reg[3] <= `LAPG_WORD_RST;
      t4d_reg <= `LAPG_HALF_RST;
      t4m_reg <= `LAPG_HALF_RST;
      mode_reg <= 1'b0;
      len_reg <= `LAPG_LEN_RST;
    end else if (ce) begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        w_held_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `LAPG_RESP_OKAY;
        if (wr_idx < `LAPG_IDX_T4D) begin
          t3_reg[wr_idx[1:0]] <= lapg_merge(t3_reg[wr_idx[1:0]],
                                            wdata_reg, wstrb_reg);
        end else if (wr_idx == `LAPG_IDX_T4D) begin
          t4d_reg <= t4d_wr_word[15:0];
        end else if (wr_idx == `LAPG_IDX_T4M) begin
          t4m_reg <= t4m_wr_word[15:0];
        end else if (wr_idx == `LAPG_IDX_CTRL) begin
          if (wstrb_reg[0]) begin
            mode_reg <= wdata_reg[`LAPG_CTRL_MODE]; // [RULE7]
            len_reg <= wdata_reg[`LAPG_CTRL_LEN_MSB:`LAPG_CTRL_LEN_LSB];
          end
        end else if (wr_idx == `LAPG_IDX_NONE) begin
          s_axi_bresp <= `LAPG_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Read channel: one read in flight, data from the decoded register
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `LAPG_WORD_RST;
      s_axi_rresp <= `LAPG_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `LAPG_RESP_OKAY;
        if (rd_idx < `LAPG_IDX_T4D) begin
          s_axi_rdata <= t3_reg[rd_idx[1:0]];
        end else if (rd_idx == `LAPG_IDX_T4D) begin
          s_axi_rdata <= {16'h0000, t4d_reg};
        end else if (rd_idx == `LAPG_IDX_T4M) begin
          s_axi_rdata <= {16'h0000, t4m_reg};
        end else if (rd_idx == `LAPG_IDX_CTRL) begin
          s_axi_rdata <= {24'h000000, len_reg, 3'h0, mode_reg};
        end else if (rd_idx == `LAPG_IDX_STAT) begin
          s_axi_rdata <= {23'h000000, m0_cell_out, 4'h0, pos_reg};
        end else begin
          s_axi_rdata <= `LAPG_WORD_RST;
          s_axi_rresp <= `LAPG_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // lapg_top

// File: tb/lapg_checker.sv
`timescale 1ns/100ps
`include "lapg_consts.vh"
// Watches bus handshakes and table outputs at the top ports
module lapg_checker (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire [47:0] m_lut3_in,
  input wire [15:0] m_lut3_out,
  input wire [3:0] m1_table_in,
  input wire m1_table_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Closing handshakes of a write and a read
  sequence s_bdone;
    s_axi_bvalid && s_axi_bready;
  endsequence
  sequence s_rdone;
    s_axi_rvalid && s_axi_rready;
  endsequence
  // Config moves only at the edge where the write answer rises
  AST_LUT3_COMB: assert property (
    $stable(m_lut3_in) && !$rose(s_axi_bvalid) |-> $stable(m_lut3_out))
    else $error("lut3 output moved alone");
  AST_T4D_COMB: assert property (
    $stable(m1_table_in) && !$rose(s_axi_bvalid) |-> $stable(m1_table_out))
    else $error("table output moved alone");
  AST_AR_TO_R: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_R_DONE: assert property (
    s_rdone |=> !s_axi_rvalid && s_axi_arready)
    else $error("read did not close");
  AST_R_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken during read");
  AST_B_DONE: assert property (
    s_bdone |=> !s_axi_bvalid && s_axi_awready)
    else $error("write did not close");
  AST_B_WAIT: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during write");
  AST_RRESP: assert property (s_axi_rvalid |->
    (s_axi_rresp == `LAPG_RESP_OKAY) ||
    (s_axi_rresp == `LAPG_RESP_SLVERR && s_axi_rdata == 32'h0))
    else $error("bad read response");
endmodule // lapg_checker

bind lapg_top lapg_checker u_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .m_lut3_in(m_lut3_in),
  .m_lut3_out(m_lut3_out), .m1_table_in(m1_table_in),
  .m1_table_out(m1_table_out));

// File: tb/lut_array_and_pattern_gen_tb_top.sv
`timescale 1ns/100ps
`include "lapg_consts.vh"
module lut_array_and_pattern_gen_tb_top;
  logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, m0_pattern_generator_clk = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf, m1_table_in = 4'h0, m0_cell_in = 4'h0;
  logic [47:0] m_lut3_in = 48'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, m1_table_out, m0_cell_out;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [15:0] m_lut3_out;
  int num_errors = 0, n_tests = 0, cyc = 0;
  logic [15:0] pat = 16'h8a96;
  logic [7:0] g3 [6] = '{8'h80, 8'h7f, 8'hfe, 8'h01, 8'h96, 8'h69};

  lapg_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .m_lut3_in(m_lut3_in),
    .m_lut3_out(m_lut3_out), .m1_table_in(m1_table_in),
    .m1_table_out(m1_table_out), .m0_cell_in(m0_cell_in),
    .m0_pattern_generator_clk(m0_pattern_generator_clk), .m0_cell_out(m0_cell_out));

  // Clock and a cycle ceiling well above the expected run
  initial forever #20 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      test_done;
    end
  end

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Expected gate output; m masks the inputs a table really uses
  function automatic logic gt(int g, logic [3:0] v, logic [3:0] m);
    case (g)
      0: return &(v | ~m);
      1: return ~&(v | ~m);
      2: return |(v & m);
      3: return ~|(v & m);
      4: return ^(v & m);
      default: return ~^(v & m);
    endcase
  endfunction

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    bit aw = 1, w = 1, b = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (aw && s_axi_awready) begin
        aw = 0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b = 1;
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    bit ar = 1, b = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (ar && s_axi_arready) begin
        ar = 0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        b = 1;
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
      end
    end
  endtask

  // Reset values, a hole in the map and the read-only status word
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
      rd(8'(4 * i), i == 6 ? 32'h0000_00f0 : 32'h0, `LAPG_RESP_OKAY);
    rd(8'h20, 32'h0, `LAPG_RESP_SLVERR);
    wr(8'h20, 32'hffff_ffff, `LAPG_RESP_SLVERR);
    wr(`LAPG_OFF_STAT, 32'hffff_ffff, `LAPG_RESP_OKAY);
    rd(`LAPG_OFF_STAT, 32'h0, `LAPG_RESP_OKAY);
    $display("test regs done");
  endtask

  // Table n gets gate n mod 6 and input value (v + n) mod 8
  task automatic t_lut3;
    logic [31:0] wd;
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 4; j++)
        wd[8 * j +: 8] = g3[(4 * k + j) % 6];
      wr(8'(4 * k), wd, `LAPG_RESP_OKAY);
    end
    for (int v = 0; v < 8; v++) begin
      @(posedge aclk);
      for (int n = 0; n < 16; n++)
        m_lut3_in[3 * n +: 3] <= 3'((v + n) % 8);
      #1;
      for (int n = 0; n < 16; n++)
        chk(m_lut3_out[n], gt(n % 6, 4'((v + n) % 8), 4'h7));
    end
    $display("test lut3 done");
  endtask

  // Dedicated table and macrocell in lookup mode, all six gates
  task automatic t_lut4;
    logic [15:0] g4 [6] = '{16'h8000, 16'h7fff, 16'hfffe, 16'h0001,
                            16'h6996, 16'h9669};
    for (int g = 0; g < 6; g++) begin
      wr(`LAPG_OFF_T4D, {16'h0, g4[g]}, `LAPG_RESP_OKAY);
      wr(`LAPG_OFF_T4M, {16'h0, g4[5 - g]}, `LAPG_RESP_OKAY);
      for (int v = 0; v < 16; v++) begin
        @(posedge aclk);
        m1_table_in <= 4'(v);
        m0_cell_in <= 4'(15 - v);
        #1;
        chk(m1_table_out, gt(g, 4'(v), 4'hf));
        chk(m0_cell_out, gt(5 - g, 4'(15 - v), 4'hf));
      end
    end
    $display("test lut4 done");
  endtask

  // Pattern wraps after the chosen length; len 0 runs as two bits
  task automatic t_gen(input logic [3:0] l);
    int lst, idx;
    lst = (l == 4'h0) ? 1 : l;
    idx = 0;
    wr(`LAPG_OFF_T4M, {16'h0, pat}, `LAPG_RESP_OKAY);
    wr(`LAPG_OFF_CTRL, {24'h0, l, 4'h1}, `LAPG_RESP_OKAY);
    chk(m0_cell_out, pat[0]);
    repeat (2 * lst + 3) begin
      m0_pattern_generator_clk <= 1'b1;
      repeat (4) @(posedge aclk);
      m0_pattern_generator_clk <= 1'b0;
      m0_cell_in <= 4'(idx);
      repeat (4) @(posedge aclk);
      idx = (idx + 1) % (lst + 1);
      chk(m0_cell_out, pat[idx]);
      rd(`LAPG_OFF_STAT, {23'h0, pat[idx], 4'h0, 4'(idx)}, `LAPG_RESP_OKAY);
    end
    wr(`LAPG_OFF_CTRL, 32'h0, `LAPG_RESP_OKAY);
    $display("test gen done");
  endtask

  // Enable low freezes the generator; bus stays idle while it is low
  task automatic t_ce;
    wr(`LAPG_OFF_CTRL, 32'h0000_00f1, `LAPG_RESP_OKAY);
    ce <= 1'b0;
    m0_pattern_generator_clk <= 1'b1;
    repeat (4) @(posedge aclk);
    m0_pattern_generator_clk <= 1'b0;
    repeat (4) @(posedge aclk);
    ce <= 1'b1;
    chk(m0_cell_out, pat[0]);
    rd(`LAPG_OFF_STAT, {23'h0, pat[0], 8'h00}, `LAPG_RESP_OKAY);
    wr(`LAPG_OFF_CTRL, 32'h0, `LAPG_RESP_OKAY);
    $display("test ce done");
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Reset for 16 cycles, then the scenarios in turn
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_lut3;
    t_lut4;
    t_gen(4'h0);
    t_gen(4'h4);
    t_gen(4'hf);
    t_ce;
    test_done;
  end
endmodule // lut_array_and_pattern_gen_tb_top
